// [src/dlwl_top.v]
// Loop relock, clock change and write leveling block with AXI4-Lite registers.
// Function
// - Device ignores its clock input while in self refresh.
// - New lock time before entry relocks on exit; after needs reset.
// - Strobe rise samples clock, value driven back on data pins.
// - Every data bit carries leveling feedback.
// - Upper lane reports upper strobe, lower lane lower strobe.
// - Device terminates strobe during leveling; controller terminates data.
// - Mode register 1 bit 7 enters and leaves write leveling.
// - Mode register 1 bit 0 low turns the loop off; a lock already counting still completes and sets loop_locked.
// - Abort bit abandons refresh on exit without counter advance.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dlwl_defines.vh"
module dlwl_top (
  input  wire        clock,
  input  wire        nrst,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ck_in,
  input  wire        cke,
  input  wire        odt,
  input  wire        sr_enter,
  input  wire        sr_exit,
  input  wire        strobe_lower,
  input  wire        strobe_upper,
  output reg  [15:0] dq_out,
  output reg  [15:0] dq_oe,
  output reg         strobe_term_on,
  output reg         loop_locked,
  output reg         in_self_refresh,
  output reg         refresh_advance
);
  localparam ST_RUN  = 3'b001;
  localparam ST_SREF = 3'b010;
  localparam ST_LOCK = 3'b100;

  // Mode register image: [0] loop enable, [7] leveling, [8] loop reset, [9] abort.
  reg [17:0] mr_reg;
  reg [2:0]  state_reg;
  reg [15:0] lock_cnt_reg;
  reg [15:0] lock_cyc_reg;
  reg        lock_new_reg;
  reg        ck_hold_reg;
  reg        aw_seen_reg;
  reg        w_seen_reg;
  reg [3:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  wire [7:0] lane_lo_out;
  wire [7:0] lane_lo_oe;
  wire [7:0] lane_hi_out;
  wire [7:0] lane_hi_oe;
  wire       wr_go;
  wire       leveling;
  wire       ck_used;

  assign wr_go    = aw_seen_reg && w_seen_reg && !s_axi_bvalid;
  assign leveling = mr_reg[`DLWL_MR1_WL_BIT];
  assign ck_used  = (state_reg == ST_SREF) ? ck_hold_reg : ck_in;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_seen_reg   <= 1'b0;
      w_seen_reg    <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_data_reg    <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_seen_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_seen_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_seen_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_seen_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg == `DLWL_ADDR_STATUS) ? 2'b10 : 2'b00;
        aw_seen_reg  <= 1'b0;
        w_seen_reg   <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `DLWL_ADDR_CTRL: begin
            s_axi_rdata <= {31'h00000000, leveling};
          end
          `DLWL_ADDR_MR: begin
            s_axi_rdata <= {14'h0000, mr_reg};
          end
          `DLWL_ADDR_STATUS: begin
            s_axi_rdata <= {26'h0000000, refresh_advance, lock_new_reg,
                            state_reg, loop_locked};
          end
          `DLWL_ADDR_LOCK: begin
            s_axi_rdata <= {16'h0000, lock_cyc_reg};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers, self refresh and loop lock.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mr_reg          <= `DLWL_MR_RST;
      state_reg       <= ST_RUN;
      lock_cnt_reg    <= 16'h0000;
      lock_cyc_reg    <= `DLWL_LOCK_CYC;
      lock_new_reg    <= 1'b0;
      ck_hold_reg     <= 1'b0;
      loop_locked     <= 1'b0;
      in_self_refresh <= 1'b0;
      refresh_advance <= 1'b0;
    end else begin
      refresh_advance <= 1'b0;
      if (wr_go && aw_addr_reg == `DLWL_ADDR_MR) begin
        mr_reg <= w_data_reg[17:0];
        if (!w_data_reg[`DLWL_MR1_LOOP_BIT]) begin
          loop_locked <= 1'b0;
        end
      end
      if (wr_go && aw_addr_reg == `DLWL_ADDR_LOCK) begin
        lock_cyc_reg <= w_data_reg[15:0];
        // lock time before or after entry
        lock_new_reg <= (state_reg == ST_RUN);
      end
      case (state_reg)
        ST_RUN: begin
          if (sr_enter && !cke) begin
            ck_hold_reg     <= ck_in;
            state_reg       <= ST_SREF;
            in_self_refresh <= 1'b1;
          end else if (wr_go && aw_addr_reg == `DLWL_ADDR_MR &&
                       w_data_reg[`DLWL_MR0_RST_BIT] &&
                       w_data_reg[`DLWL_MR1_LOOP_BIT]) begin
            state_reg    <= ST_LOCK;
            lock_cnt_reg <= lock_cyc_reg;
            loop_locked  <= 1'b0;
          end
        end
        ST_SREF: begin
          if (sr_exit && cke) begin
            in_self_refresh <= 1'b0;
            refresh_advance <= !mr_reg[`DLWL_MR4_ABORT_BIT];
            if (lock_new_reg && mr_reg[`DLWL_MR1_LOOP_BIT]) begin
              state_reg    <= ST_LOCK;
              lock_cnt_reg <= lock_cyc_reg;
              loop_locked  <= 1'b0;
              lock_new_reg <= 1'b0;
            end else begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_LOCK: begin
          if (lock_cnt_reg <= 16'h0001) begin
            state_reg   <= ST_RUN;
            loop_locked <= 1'b1;
          end else begin
            lock_cnt_reg <= lock_cnt_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write leveling feedback and termination.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dq_out         <= 16'h0000;
      dq_oe          <= 16'h0000;
      strobe_term_on <= 1'b0;
    end else begin
      dq_out <= {lane_hi_out, lane_lo_out};
      dq_oe  <= {lane_hi_oe, lane_lo_oe};
      strobe_term_on <= leveling;
    end
  end

  dlwl_lane u_lane_lo (
    .clock       (clock),
    .nrst        (nrst),
    .lane_strobe (strobe_lower),
    .lane_ck     (ck_used),
    .lane_enable (leveling),
    .lane_dq_out (lane_lo_out),
    .lane_dq_oe  (lane_lo_oe)
  );

  dlwl_lane u_lane_hi (
    .clock       (clock),
    .nrst        (nrst),
    .lane_strobe (strobe_upper),
    .lane_ck     (ck_used),
    .lane_enable (leveling),
    .lane_dq_out (lane_hi_out),
    .lane_dq_oe  (lane_hi_oe)
  );
endmodule // dlwl_top

// [src/dlwl_defines.vh]
// Constants for the loop relock, clock change and write leveling block.
`ifndef DLWL_DEFINES_VH
`define DLWL_DEFINES_VH
`define DLWL_ADDR_CTRL     4'h0
`define DLWL_ADDR_MR       4'h4
`define DLWL_ADDR_STATUS   4'h8
`define DLWL_ADDR_LOCK     4'hC
`define DLWL_MR1_LOOP_BIT  0
`define DLWL_MR1_WL_BIT    7
`define DLWL_MR1_QOFF_BIT  12
`define DLWL_MR0_RST_BIT   8
`define DLWL_MR4_ABORT_BIT 9
`define DLWL_MR5_PL_MSB    2
`define DLWL_CLK_MHZ       25
`define DLWL_LOCK_NS       2000
`define DLWL_LOCK_CYC      16'h0032
`define DLWL_MR_RST        18'h00000
`endif

// [src/dlwl_lane.v]
// One byte lane of write leveling feedback.
`timescale 1ns/1ps
module dlwl_lane (
  input  wire       clock,
  input  wire       nrst,
  input  wire       lane_strobe,
  input  wire       lane_ck,
  input  wire       lane_enable,
  output reg  [7:0] lane_dq_out,
  output reg  [7:0] lane_dq_oe
);
  reg strobe_d_reg;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_d_reg <= 1'b0;
      lane_dq_out  <= 8'h00;
      lane_dq_oe   <= 8'h00;
    end else begin
      strobe_d_reg <= lane_strobe;
      lane_dq_oe   <= {8{lane_enable}};
      if (lane_enable && lane_strobe && !strobe_d_reg) begin
        lane_dq_out <= {8{lane_ck}};
      end else if (!lane_enable) begin
        lane_dq_out <= 8'h00;
      end
    end
  end
endmodule // dlwl_lane

// [sim/dlwl_asserts.sv]
// Assertions on the ports of the loop relock and leveling block.
`timescale 1ns/1ps
module dlwl_asserts (
  input wire        clock,
  input wire        nrst,
  input wire        s_axi_awready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        ck_in,
  input wire        cke,
  input wire        sr_enter,
  input wire        strobe_lower,
  input wire        strobe_upper,
  input wire [15:0] dq_out,
  input wire [15:0] dq_oe,
  input wire        strobe_term_on,
  input wire        in_self_refresh,
  input wire        refresh_advance
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence lvl_lo_s;
    $rose(strobe_lower) && strobe_term_on;
  endsequence
  sequence lvl_up_s;
    $rose(strobe_upper) && strobe_term_on;
  endsequence
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  lane_lower_a: assert property (
    lvl_lo_s |-> ##[1:3] dq_out[7:0] == {8{ck_in}}) else $error("lower lane wrong");
  lane_upper_a: assert property (
    lvl_up_s |-> ##[1:3] dq_out[15:8] == {8{ck_in}}) else $error("upper lane wrong");
  level_oe_a: assert property (
    strobe_term_on [*4] |-> dq_oe == 16'hFFFF) else $error("feedback not driven");
  quiet_oe_a: assert property (
    !strobe_term_on [*4] |-> dq_oe == 16'h0000) else $error("feedback driven idle");
  sr_entry_a: assert property (!cke && sr_enter |-> ##[1:2] in_self_refresh)
    else $error("self refresh not entered");
  refresh_adv_a: assert property (
    refresh_advance |-> !in_self_refresh ##1 !refresh_advance) else $error("bad advance");
endmodule // dlwl_asserts
bind dlwl_top dlwl_asserts dlwl_asserts_i (.clock, .nrst, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .ck_in, .cke, .sr_enter, .strobe_lower, .strobe_upper, .dq_out, .dq_oe,
  .strobe_term_on, .in_self_refresh, .refresh_advance);

// [sim/dlwl_ctrl_model.sv]
// Memory controller model driving clock level, enables and strobes.
`timescale 1ns/1ps
module dlwl_ctrl_model (
  input  wire  clock,
  output logic ck_in = 1'h0,
  output logic cke = 1'h1,
  output logic odt = 1'h0,
  output logic sr_enter = 1'h0,
  output logic sr_exit = 1'h0,
  output logic strobe_lower = 1'h0,
  output logic strobe_upper = 1'h0
);
  task level(input bit up, input bit ck);
    ck_in <= ck;
    @(posedge clock);
    if (up) strobe_upper <= 1'h1;
    else strobe_lower <= 1'h1;
    repeat (4) @(posedge clock);
    strobe_upper <= 1'h0;
    strobe_lower <= 1'h0;
    @(posedge clock);
  endtask
  task sref;
    cke <= 1'h0;
    @(posedge clock);
    sr_enter <= 1'h1;
    @(posedge clock);
    sr_enter <= 1'h0;
    repeat (3) begin
      @(posedge clock);
      ck_in <= ~ck_in;
    end
    cke <= 1'h1;
    @(posedge clock);
    sr_exit <= 1'h1;
    @(posedge clock);
    sr_exit <= 1'h0;
    repeat (4) @(posedge clock);
  endtask
endmodule // dlwl_ctrl_model

// [sim/dlwl_top_tb.sv]
// Self-checking bench for the loop relock and leveling block.
`timescale 1ns/1ps
`include "dlwl_defines.vh"
module dlwl_top_tb;
  logic        clock = 1'h0, nrst = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h9765E1E8;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, ck_in, cke, odt;
  logic        sr_enter, sr_exit, strobe_lower, strobe_upper, strobe_term_on;
  logic        loop_locked, in_self_refresh, refresh_advance;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] dq_out, dq_oe;
  logic [33:0] exp_q[$];
  int          mismatches = 0, n_tests = 0, adv = 0, k;
  always #20 clock = ~clock;
  dlwl_top dlwl_top_i (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ck_in, .cke, .odt, .sr_enter,
    .sr_exit, .strobe_lower, .strobe_upper, .dq_out, .dq_oe, .strobe_term_on, .loop_locked,
    .in_self_refresh, .refresh_advance);
  dlwl_ctrl_model dlwl_ctrl_model_i (.clock, .ck_in, .cke, .odt, .sr_enter, .sr_exit,
    .strobe_lower, .strobe_upper);
  ////////////////////////////////////////////////////////////////////////////////////////
  task summarize;
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clock) begin
    if (refresh_advance === 1'h1) adv++;
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  task xfer(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    exp_q.push_back({r, w ? 32'h0 : d});
    for (n = 0; n < 50 && !s_axi_bvalid && !s_axi_rvalid; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (n == 50) begin
      mismatches++;
      summarize;
    end
    @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'h1;
    xfer(0, 4'hC, `DLWL_LOCK_CYC, 2'h0);
    xfer(0, 4'h2, 32'h0, 2'h2);
    xfer(1, 4'h8, 32'h1, 2'h2);
    rnd = lfsr(rnd);
    xfer(1, 4'h4, rnd & 32'h3FC7E, 2'h0);
    xfer(0, 4'h4, rnd & 32'h3FC7E, 2'h0);
    xfer(1, 4'h4, 32'h80, 2'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      dlwl_ctrl_model_i.level(0, rnd[0]);
      dlwl_ctrl_model_i.level(1, rnd[1]);
      chk({dq_oe, dq_out}, {16'hFFFF, {8{rnd[1]}}, {8{rnd[0]}}});
    end
    chk(strobe_term_on, 1'h1);
    xfer(1, 4'h4, 32'h0, 2'h0);
    repeat (3) @(posedge clock);
    chk({strobe_term_on, dq_oe}, 17'h0);
    xfer(1, 4'h4, 32'h101, 2'h0);
    for (k = 0; k < 100 && loop_locked !== 1'h1; k++) @(posedge clock);
    chk(k >= `DLWL_LOCK_CYC - 8 && k < 100, 1'h1);
    xfer(1, 4'hC, 32'h14, 2'h0);
    dlwl_ctrl_model_i.sref;
    chk(adv, 1);
    chk(loop_locked, 1'h0);
    for (k = 0; k < 100 && loop_locked !== 1'h1; k++) @(posedge clock);
    chk(k >= 12 && k < 100, 1'h1);
    xfer(1, 4'h4, 32'h200, 2'h0);
    chk(loop_locked, 1'h0);
    dlwl_ctrl_model_i.sref;
    chk(adv, 1);
    summarize;
  end
endmodule // dlwl_top_tb
